/* File: verilog/htu_regs.svh */
// Constants of the high-dynamic-range texture block unpacker.
// Assumes inclusion by the package and the unpacker modules.
`ifndef HTU_REGS_SVH
`define HTU_REGS_SVH

// ----------------------------------------
// Block geometry
// ----------------------------------------
`define HTU_BLOCK_W 128
`define HTU_EP_W 16
`define HTU_LATENCY 2
`define HTU_SPLIT_MODE 2'h2

// ----------------------------------------
// Field variable codes of the format tables
// ----------------------------------------
`define HTU_V_R0 4'h0
`define HTU_V_G0 4'h1
`define HTU_V_B0 4'h2
`define HTU_V_R1 4'h3
`define HTU_V_G1 4'h4
`define HTU_V_B1 4'h5
`define HTU_V_R2 4'h6
`define HTU_V_G2 4'h7
`define HTU_V_B2 4'h8
`define HTU_V_R3 4'h9
`define HTU_V_G3 4'hA
`define HTU_V_B3 4'hB
`define HTU_V_END 4'hE
`define HTU_V_MODE 4'hF

// ----------------------------------------
// Mode parameters: transformed, partition bits, base bits, deltas r g b
// ----------------------------------------
`define HTU_P_M0 {1'h1, 5'h05, 5'h0A, 5'h05, 5'h05, 5'h05}
`define HTU_P_M1 {1'h1, 5'h05, 5'h07, 5'h06, 5'h06, 5'h06}
`define HTU_P_M2 {1'h1, 5'h05, 5'h0B, 5'h05, 5'h04, 5'h04}
`define HTU_P_M6 {1'h1, 5'h05, 5'h0B, 5'h04, 5'h05, 5'h04}
`define HTU_P_M10 {1'h1, 5'h05, 5'h0B, 5'h04, 5'h04, 5'h05}
`define HTU_P_M14 {1'h1, 5'h05, 5'h09, 5'h05, 5'h05, 5'h05}
`define HTU_P_M18 {1'h1, 5'h05, 5'h08, 5'h06, 5'h05, 5'h05}
`define HTU_P_M22 {1'h1, 5'h05, 5'h08, 5'h05, 5'h06, 5'h05}
`define HTU_P_M26 {1'h1, 5'h05, 5'h08, 5'h05, 5'h05, 5'h06}
`define HTU_P_M30 {1'h0, 5'h05, 5'h06, 5'h06, 5'h06, 5'h06}
`define HTU_P_M3 {1'h0, 5'h00, 5'h0A, 5'h0A, 5'h0A, 5'h0A}
`define HTU_P_M7 {1'h1, 5'h00, 5'h0B, 5'h09, 5'h09, 5'h09}
`define HTU_P_M11 {1'h1, 5'h00, 5'h0C, 5'h08, 5'h08, 5'h08}
`define HTU_P_M15 {1'h1, 5'h00, 5'h10, 5'h04, 5'h04, 5'h04}

// ----------------------------------------
// Mode numbers
// ----------------------------------------
`define HTU_M0 5'h00
`define HTU_M1 5'h01
`define HTU_M2 5'h02
`define HTU_M3 5'h03
`define HTU_M6 5'h06
`define HTU_M7 5'h07
`define HTU_M10 5'h0A
`define HTU_M11 5'h0B
`define HTU_M14 5'h0E
`define HTU_M15 5'h0F
`define HTU_M18 5'h12
`define HTU_M22 5'h16
`define HTU_M26 5'h1A
`define HTU_M30 5'h1E

`endif

/* File: verilog/htu_pkg.sv */
// Types shared by the texture block unpacker modules.
// Assumes htu_regs.svh for widths.
`default_nettype none
`include "htu_regs.svh"

package htu_pkg;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef logic [`HTU_EP_W-1:0] htu_ep_t;

	typedef struct packed {
		logic trans;
		logic [4:0] pbw;
		logic [4:0] epbw;
		logic [4:0] dr;
		logic [4:0] dg;
		logic [4:0] db;
	} htu_mode_param_t;

	typedef struct packed {
		logic s1_vld;
		logic [`HTU_BLOCK_W-1:0] s1_blk;
		logic o_vld;
		logic o_err;
		logic [4:0] o_mode;
		htu_mode_param_t o_par;
		logic [4:0] o_part;
		logic [`HTU_BLOCK_W-1:0] o_idx;
		logic [11:0][`HTU_EP_W-1:0] o_ep;
	} htu_state_t;

endpackage

`default_nettype wire

/* File: verilog/htu_mode_decode.sv */
// Mode decoder: picks the mode number and its parameters from the block's low bits.
// Assumes a registered block on the input; purely combinational.
`default_nettype none
`include "htu_regs.svh"

module htu_mode_decode
	import htu_pkg::*;
(
	// Block low bits
	input wire logic [4:0] low_bits,
	// Decoded mode
	output logic [4:0] mode,
	output logic [3:0] sel,
	output logic legal,
	output htu_mode_param_t par
);

	always_comb begin
		mode = (low_bits[1:0] < `HTU_SPLIT_MODE) ? {3'h0, low_bits[1:0]} : low_bits;
		legal = 1'b1;
		sel = 4'h0;
		par = '0;
		case (mode)
			`HTU_M0: begin par = `HTU_P_M0; sel = 4'h0; end
			`HTU_M1: begin par = `HTU_P_M1; sel = 4'h1; end
			`HTU_M2: begin par = `HTU_P_M2; sel = 4'h2; end
			`HTU_M6: begin par = `HTU_P_M6; sel = 4'h3; end
			`HTU_M10: begin par = `HTU_P_M10; sel = 4'h4; end
			`HTU_M14: begin par = `HTU_P_M14; sel = 4'h5; end
			`HTU_M18: begin par = `HTU_P_M18; sel = 4'h6; end
			`HTU_M22: begin par = `HTU_P_M22; sel = 4'h7; end
			`HTU_M26: begin par = `HTU_P_M26; sel = 4'h8; end
			`HTU_M30: begin par = `HTU_P_M30; sel = 4'h9; end
			`HTU_M3: begin par = `HTU_P_M3; sel = 4'hA; end
			`HTU_M7: begin par = `HTU_P_M7; sel = 4'hB; end
			`HTU_M11: begin par = `HTU_P_M11; sel = 4'hC; end
			`HTU_M15: begin par = `HTU_P_M15; sel = 4'hD; end
			default: begin
				legal = 1'b0;
			end
		endcase
	end

endmodule

`default_nettype wire

/* File: verilog/htu_ep_transform.sv */
// Endpoint transform: offsets every endpoint but the first by the first, wrapped.
// Assumes scattered raw endpoints on the input; purely combinational.
`default_nettype none
`include "htu_regs.svh"

module htu_ep_transform
	import htu_pkg::*;
(
	// Controls
	input wire logic trans,
	input wire logic [4:0] epbw,
	// Endpoints: base r g b, then nine others
	input wire logic [2:0][`HTU_EP_W-1:0] base,
	input wire logic [8:0][`HTU_EP_W-1:0] ep_in,
	output logic [8:0][`HTU_EP_W-1:0] ep_out
);

	logic [`HTU_EP_W-1:0] mask;

	assign mask = 16'((32'h1 << epbw) - 32'h1);

	genvar k;
	generate
		for (k = 0; k < 9; k++) begin : g_chan
			logic [`HTU_EP_W-1:0] sum;
			assign sum = ep_in[k] + base[k % 3];
			assign ep_out[k] = trans ? (sum & mask) : ep_in[k];
		end
	endgenerate

endmodule

`default_nettype wire

/* File: verilog/htu_unpacker.sv */
// Top of the texture block unpacker: mode decode, field scatter, endpoint transform.
// Assumes one 128-bit block per valid cycle from the fetch side; no back-pressure.
`default_nettype none
`include "htu_regs.svh"

module htu_unpacker
	import htu_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Block input
	input wire logic in_valid,
	input wire logic [`HTU_BLOCK_W-1:0] in_block,
	// Mode information
	output logic out_valid,
	output logic out_error,
	output logic [4:0] out_mode,
	output logic out_transformed,
	output logic [4:0] partition_index_width,
	output logic [4:0] base_endpoint_width,
	output logic [4:0] out_delta_red_width,
	output logic [4:0] out_delta_green_width,
	output logic [4:0] out_delta_blue_width,
	// Partition and index data
	output logic [4:0] out_partition_index,
	output logic [`HTU_BLOCK_W-1:0] out_index_data,
	// Endpoints
	output logic [`HTU_EP_W-1:0] red_endpoint_zero,
	output logic [`HTU_EP_W-1:0] green_endpoint_zero,
	output logic [`HTU_EP_W-1:0] blue_endpoint_zero,
	output logic [`HTU_EP_W-1:0] red_endpoint_one,
	output logic [`HTU_EP_W-1:0] green_endpoint_one,
	output logic [`HTU_EP_W-1:0] blue_endpoint_one,
	output logic [`HTU_EP_W-1:0] red_endpoint_two,
	output logic [`HTU_EP_W-1:0] green_endpoint_two,
	output logic [`HTU_EP_W-1:0] blue_endpoint_two,
	output logic [`HTU_EP_W-1:0] red_endpoint_three,
	output logic [`HTU_EP_W-1:0] green_endpoint_three,
	output logic [`HTU_EP_W-1:0] blue_endpoint_three
);

	// ----------------------------------------
	// Format tables
	// ----------------------------------------
	localparam logic [3:0] R0 = `HTU_V_R0;
	localparam logic [3:0] G0 = `HTU_V_G0;
	localparam logic [3:0] B0 = `HTU_V_B0;
	localparam logic [3:0] R1 = `HTU_V_R1;
	localparam logic [3:0] G1 = `HTU_V_G1;
	localparam logic [3:0] B1 = `HTU_V_B1;
	localparam logic [3:0] R2 = `HTU_V_R2;
	localparam logic [3:0] G2 = `HTU_V_G2;
	localparam logic [3:0] B2 = `HTU_V_B2;
	localparam logic [3:0] R3 = `HTU_V_R3;
	localparam logic [3:0] G3 = `HTU_V_G3;
	localparam logic [3:0] B3 = `HTU_V_B3;
	localparam logic [3:0] MD = `HTU_V_MODE;
	localparam int ENT_MAX = 24;

	function automatic logic [11:0] e(input logic [3:0] v, input int a, input int b);
		return {v, 4'(a), 4'(b)};
	endfunction

	localparam F0 = {e(MD, 1, 0), e(G2, 4, 4), e(B2, 4, 4), e(B3, 4, 4), e(R0, 9, 0), e(G0, 9, 0), e(B0, 9, 0),
		e(R1, 4, 0), e(G3, 4, 4), e(G2, 3, 0), e(G1, 4, 0), e(B3, 0, 0), e(G3, 3, 0), e(B1, 4, 0), e(B3, 1, 1),
		e(B2, 3, 0), e(R2, 4, 0), e(B3, 2, 2), e(R3, 4, 0), e(B3, 3, 3)};
	localparam F1 = {e(MD, 1, 0), e(G2, 5, 5), e(G3, 4, 4), e(G3, 5, 5), e(R0, 6, 0), e(B3, 0, 0), e(B3, 1, 1),
		e(B2, 4, 4), e(G0, 6, 0), e(B2, 5, 5), e(B3, 2, 2), e(G2, 4, 4), e(B0, 6, 0), e(B3, 3, 3), e(B3, 5, 5),
		e(B3, 4, 4), e(R1, 5, 0), e(G2, 3, 0), e(G1, 5, 0), e(G3, 3, 0), e(B1, 5, 0), e(B2, 3, 0), e(R2, 5, 0),
		e(R3, 5, 0)};
	localparam F2 = {e(MD, 4, 0), e(R0, 9, 0), e(G0, 9, 0), e(B0, 9, 0), e(R1, 4, 0), e(R0, 10, 10), e(G2, 3, 0),
		e(G1, 3, 0), e(G0, 10, 10), e(B3, 0, 0), e(G3, 3, 0), e(B1, 3, 0), e(B0, 10, 10), e(B3, 1, 1),
		e(B2, 3, 0), e(R2, 4, 0), e(B3, 2, 2), e(R3, 4, 0), e(B3, 3, 3)};
	localparam F6 = {e(MD, 4, 0), e(R0, 9, 0), e(G0, 9, 0), e(B0, 9, 0), e(R1, 3, 0), e(R0, 10, 10), e(G3, 4, 4),
		e(G2, 3, 0), e(G1, 4, 0), e(G0, 10, 10), e(G3, 3, 0), e(B1, 3, 0), e(B0, 10, 10), e(B3, 1, 1),
		e(B2, 3, 0), e(R2, 3, 0), e(B3, 0, 0), e(B3, 2, 2), e(R3, 3, 0), e(G2, 4, 4), e(B3, 3, 3)};
	localparam F10 = {e(MD, 4, 0), e(R0, 9, 0), e(G0, 9, 0), e(B0, 9, 0), e(R1, 3, 0), e(R0, 10, 10), e(B2, 4, 4),
		e(G2, 3, 0), e(G1, 3, 0), e(G0, 10, 10), e(B3, 0, 0), e(G3, 3, 0), e(B1, 4, 0), e(B0, 10, 10),
		e(B2, 3, 0), e(R2, 3, 0), e(B3, 1, 1), e(B3, 2, 2), e(R3, 3, 0), e(B3, 4, 4), e(B3, 3, 3)};
	localparam F14 = {e(MD, 4, 0), e(R0, 8, 0), e(B2, 4, 4), e(G0, 8, 0), e(G2, 4, 4), e(B0, 8, 0), e(B3, 4, 4),
		e(R1, 4, 0), e(G3, 4, 4), e(G2, 3, 0), e(G1, 4, 0), e(B3, 0, 0), e(G3, 3, 0), e(B1, 4, 0), e(B3, 1, 1),
		e(B2, 3, 0), e(R2, 4, 0), e(B3, 2, 2), e(R3, 4, 0), e(B3, 3, 3)};
	localparam F18 = {e(MD, 4, 0), e(R0, 7, 0), e(G3, 4, 4), e(B2, 4, 4), e(G0, 7, 0), e(B3, 2, 2), e(G2, 4, 4),
		e(B0, 7, 0), e(B3, 3, 3), e(B3, 4, 4), e(R1, 5, 0), e(G2, 3, 0), e(G1, 4, 0), e(B3, 0, 0), e(G3, 3, 0),
		e(B1, 4, 0), e(B3, 1, 1), e(B2, 3, 0), e(R2, 5, 0), e(R3, 5, 0)};
	localparam F22 = {e(MD, 4, 0), e(R0, 7, 0), e(B3, 0, 0), e(B2, 4, 4), e(G0, 7, 0), e(G2, 5, 5), e(G2, 4, 4),
		e(B0, 7, 0), e(G3, 5, 5), e(B3, 4, 4), e(R1, 4, 0), e(G3, 4, 4), e(G2, 3, 0), e(G1, 5, 0), e(G3, 3, 0),
		e(B1, 4, 0), e(B3, 1, 1), e(B2, 3, 0), e(R2, 4, 0), e(B3, 2, 2), e(R3, 4, 0), e(B3, 3, 3)};
	localparam F26 = {e(MD, 4, 0), e(R0, 7, 0), e(B3, 1, 1), e(B2, 4, 4), e(G0, 7, 0), e(B2, 5, 5), e(G2, 4, 4),
		e(B0, 7, 0), e(B3, 5, 5), e(B3, 4, 4), e(R1, 4, 0), e(G3, 4, 4), e(G2, 3, 0), e(G1, 4, 0), e(B3, 0, 0),
		e(G3, 3, 0), e(B1, 5, 0), e(B2, 3, 0), e(R2, 4, 0), e(B3, 2, 2), e(R3, 4, 0), e(B3, 3, 3)};
	localparam F30 = {e(MD, 4, 0), e(R0, 5, 0), e(G3, 4, 4), e(B3, 0, 0), e(B3, 1, 1), e(B2, 4, 4), e(G0, 5, 0),
		e(G2, 5, 5), e(B2, 5, 5), e(B3, 2, 2), e(G2, 4, 4), e(B0, 5, 0), e(G3, 5, 5), e(B3, 3, 3), e(B3, 5, 5),
		e(B3, 4, 4), e(R1, 5, 0), e(G2, 3, 0), e(G1, 5, 0), e(G3, 3, 0), e(B1, 5, 0), e(B2, 3, 0), e(R2, 5, 0),
		e(R3, 5, 0)};
	localparam F3 = {e(MD, 4, 0), e(R0, 9, 0), e(G0, 9, 0), e(B0, 9, 0), e(R1, 9, 0), e(G1, 9, 0), e(B1, 9, 0)};
	localparam F7 = {e(MD, 4, 0), e(R0, 9, 0), e(G0, 9, 0), e(B0, 9, 0), e(R1, 8, 0), e(R0, 10, 10), e(G1, 8, 0),
		e(G0, 10, 10), e(B1, 8, 0), e(B0, 10, 10)};
	localparam F11 = {e(MD, 4, 0), e(R0, 9, 0), e(G0, 9, 0), e(B0, 9, 0), e(R1, 7, 0), e(R0, 10, 11),
		e(G1, 7, 0), e(G0, 10, 11), e(B1, 7, 0), e(B0, 10, 11)};
	localparam F15 = {e(MD, 4, 0), e(R0, 9, 0), e(G0, 9, 0), e(B0, 9, 0), e(R1, 3, 0), e(R0, 10, 15),
		e(G1, 3, 0), e(G0, 10, 15), e(B1, 3, 0), e(B0, 10, 15)};

	// Entry i of a table, first entry leftmost; past the end reads as end marker
	function automatic logic [11:0] pick(input logic [12*ENT_MAX-1:0] v, input int n, input int i);
		if (i < n)
			return v[12*(n-1-i) +: 12];
		return {`HTU_V_END, 8'h00};
	endfunction

	function automatic logic [11:0] entry(input logic [3:0] sel, input int i);
		case (sel)
			4'h0: return pick(F0, $bits(F0) / 12, i);
			4'h1: return pick(F1, $bits(F1) / 12, i);
			4'h2: return pick(F2, $bits(F2) / 12, i);
			4'h3: return pick(F6, $bits(F6) / 12, i);
			4'h4: return pick(F10, $bits(F10) / 12, i);
			4'h5: return pick(F14, $bits(F14) / 12, i);
			4'h6: return pick(F18, $bits(F18) / 12, i);
			4'h7: return pick(F22, $bits(F22) / 12, i);
			4'h8: return pick(F26, $bits(F26) / 12, i);
			4'h9: return pick(F30, $bits(F30) / 12, i);
			4'hA: return pick(F3, $bits(F3) / 12, i);
			4'hB: return pick(F7, $bits(F7) / 12, i);
			4'hC: return pick(F11, $bits(F11) / 12, i);
			4'hD: return pick(F15, $bits(F15) / 12, i);
			default: return {`HTU_V_END, 8'h00};
		endcase
	endfunction

	// ----------------------------------------
	// Decode and scatter
	// ----------------------------------------
	htu_state_t st_r;
	htu_state_t st_nxt;
	logic [4:0] dec_mode;
	logic [3:0] dec_sel;
	logic dec_legal;
	htu_mode_param_t dec_par;
	logic [11:0][`HTU_EP_W-1:0] scat;
	logic [8:0][`HTU_EP_W-1:0] xformed;
	logic [7:0] tail_pos;

	htu_mode_decode u_dec (
		.low_bits(st_r.s1_blk[4:0]),
		.mode(dec_mode),
		.sel(dec_sel),
		.legal(dec_legal),
		.par(dec_par)
	);

	always_comb begin
		logic [11:0] ent;
		int pos;
		int nb;
		int a;
		int b;
		int dst;
		ent = '0;
		pos = 0;
		nb = 0;
		a = 0;
		b = 0;
		dst = 0;
		scat = '0;
		for (int i = 0; i < ENT_MAX; i++) begin
			ent = entry(dec_sel, i);
			a = int'(ent[7:4]);
			b = int'(ent[3:0]);
			nb = (a >= b) ? (a - b + 1) : (b - a + 1);
			if (ent[11:8] != `HTU_V_END) begin
				for (int k = 0; k < `HTU_EP_W; k++) begin
					if (k < nb && pos < `HTU_BLOCK_W) begin
						dst = (a >= b) ? (b + k) : (b - k);
						if (ent[11:8] != `HTU_V_MODE)
							scat[ent[11:8]][dst] = st_r.s1_blk[pos];
						pos = pos + 1;
					end
				end
			end
		end
		tail_pos = 8'(pos);
	end

	htu_ep_transform u_xf (
		.trans(dec_par.trans),
		.epbw(dec_par.epbw),
		.base(scat[2:0]),
		.ep_in(scat[11:3]),
		.ep_out(xformed)
	);

	// ----------------------------------------
	// Pipeline state
	// ----------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.s1_vld = in_valid;
		st_nxt.s1_blk = in_block;
		st_nxt.o_vld = st_r.s1_vld;
		st_nxt.o_err = st_r.s1_vld & ~dec_legal;
		st_nxt.o_mode = dec_mode;
		st_nxt.o_par = dec_par;
		st_nxt.o_part = 5'((st_r.s1_blk >> tail_pos) & {123'h0, 5'h1F} & ((128'h1 << dec_par.pbw) - 128'h1));
		st_nxt.o_idx = st_r.s1_blk >> (tail_pos + 8'(dec_par.pbw));
		st_nxt.o_ep = {xformed, scat[2:0]};
		if (!dec_legal) begin
			st_nxt.o_part = '0;
			st_nxt.o_idx = '0;
			st_nxt.o_ep = '0;
		end
		if (rst)
			st_nxt = '0;
	end

	always_ff @(posedge clk) begin
		st_r <= st_nxt;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign out_valid = st_r.o_vld;
	assign out_error = st_r.o_err;
	assign out_mode = st_r.o_mode;
	assign out_transformed = st_r.o_par.trans;
	assign partition_index_width = st_r.o_par.pbw;
	assign base_endpoint_width = st_r.o_par.epbw;
	assign out_delta_red_width = st_r.o_par.dr;
	assign out_delta_green_width = st_r.o_par.dg;
	assign out_delta_blue_width = st_r.o_par.db;
	assign out_partition_index = st_r.o_part;
	assign out_index_data = st_r.o_idx;
	assign red_endpoint_zero = st_r.o_ep[0];
	assign green_endpoint_zero = st_r.o_ep[1];
	assign blue_endpoint_zero = st_r.o_ep[2];
	assign red_endpoint_one = st_r.o_ep[3];
	assign green_endpoint_one = st_r.o_ep[4];
	assign blue_endpoint_one = st_r.o_ep[5];
	assign red_endpoint_two = st_r.o_ep[6];
	assign green_endpoint_two = st_r.o_ep[7];
	assign blue_endpoint_two = st_r.o_ep[8];
	assign red_endpoint_three = st_r.o_ep[9];
	assign green_endpoint_three = st_r.o_ep[10];
	assign blue_endpoint_three = st_r.o_ep[11];

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_latency;
		in_valid ##1 !rst |-> ##1 out_valid;
	endproperty
	a_latency: assert property (p_latency) else $error("valid block not presented after two cycles");

	property p_short_mode;
		in_valid && in_block[1:0] < 2'h2 ##1 !rst |-> ##1 out_mode == {3'h0, $past(in_block[1:0], 2)};
	endproperty
	a_short_mode: assert property (p_short_mode) else $error("two-bit mode code misdecoded");

	property p_reserved;
		in_valid && in_block[4:0] == 5'h13 ##1 !rst |-> ##1 out_error && out_valid;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved mode not flagged");

	property p_error_zero;
		out_error |-> red_endpoint_zero == '0 && blue_endpoint_three == '0 && out_index_data == '0;
	endproperty
	a_error_zero: assert property (p_error_zero) else $error("errored block carries data");

	property p_wrap;
		out_valid && out_transformed && !out_error |->
			(32'(red_endpoint_one) >> base_endpoint_width) == 32'h0 &&
			(32'(blue_endpoint_three) >> base_endpoint_width) == 32'h0;
	endproperty
	a_wrap: assert property (p_wrap) else $error("transformed endpoint exceeds base width");

	property p_mode0;
		in_valid && in_block[1:0] == 2'h0 ##1 !rst |-> ##1
			base_endpoint_width == 5'h0A && partition_index_width == 5'h05 && out_transformed;
	endproperty
	a_mode0: assert property (p_mode0) else $error("mode 0 parameters wrong");

	property p_mode3;
		in_valid && in_block[4:0] == `HTU_M3 ##1 !rst |-> ##1 !out_transformed &&
			red_endpoint_zero == {6'h00, $past(in_block[14:5], 2)} &&
			red_endpoint_one == {6'h00, $past(in_block[44:35], 2)};
	endproperty
	a_mode3: assert property (p_mode3) else $error("mode 3 plain endpoints wrong");

	property p_mode11_rev;
		in_valid && in_block[4:0] == `HTU_M11 ##1 !rst |-> ##1
			red_endpoint_zero[11] == $past(in_block[43], 2) && red_endpoint_zero[10] == $past(in_block[44], 2);
	endproperty
	a_mode11_rev: assert property (p_mode11_rev) else $error("reversed top bits misplaced");

	property p_mode30;
		in_valid && in_block[4:0] == `HTU_M30 ##1 !rst |-> ##1
			!out_transformed && base_endpoint_width == 5'h06 && red_endpoint_one[15:6] == '0;
	endproperty
	a_mode30: assert property (p_mode30) else $error("mode 30 not plain six-bit");

endmodule

`default_nettype wire

/* File: verification/htu_fetch_model.sv */
// Fetch-side model: hands one block per clock to the unpacker while go is high.
// Assumes the bench raises go just after a rising edge of clk.
`default_nettype none

module htu_fetch_model (
	// Clock
	input wire logic clk,
	// Bench side
	input wire logic go,
	input wire logic [127:0] blk,
	// Unpacker side
	output logic in_valid,
	output logic [127:0] in_block
);
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------
	// Idle bus toggles so stale data never looks valid
	// ----------------------------------------
	logic [127:0] junk_r = 128'h0;

	always @(posedge clk) begin
		junk_r <= ~junk_r;
	end

	assign in_valid = go;
	assign in_block = go ? blk : junk_r;
endmodule

`default_nettype wire

/* File: verification/test_hdr_texture_block_unpacker.sv */
// Bench of the texture block unpacker: mode table, field scatter, latency.
// Assumes the fetch model in front of the unpacker; one clock, sync reset.
`default_nettype none
`include "htu_regs.svh"

module test_hdr_texture_block_unpacker;
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------
	// Harness
	// ----------------------------------------
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic go = 1'b0;
	logic [127:0] blk = 128'h0;
	wire logic in_valid, vld;
	wire logic [127:0] in_block, idx;
	wire logic [4:0] part;
	wire logic [31:0] info;
	wire logic [191:0] eps;
	int fail_count = 0;
	int check_count = 0;

	always #5 clk = ~clk;

	htu_fetch_model u_fetch (.clk(clk), .go(go), .blk(blk), .in_valid(in_valid), .in_block(in_block));

	htu_unpacker u_dut (
		.clk(clk), .rst(rst), .in_valid(in_valid), .in_block(in_block), .out_valid(vld),
		.out_error(info[31]), .out_mode(info[30:26]), .out_transformed(info[25]),
		.partition_index_width(info[24:20]), .base_endpoint_width(info[19:15]),
		.out_delta_red_width(info[14:10]), .out_delta_green_width(info[9:5]),
		.out_delta_blue_width(info[4:0]), .out_partition_index(part), .out_index_data(idx),
		.red_endpoint_zero(eps[191:176]), .green_endpoint_zero(eps[175:160]),
		.blue_endpoint_zero(eps[159:144]), .red_endpoint_one(eps[143:128]),
		.green_endpoint_one(eps[127:112]), .blue_endpoint_one(eps[111:96]),
		.red_endpoint_two(eps[95:80]), .green_endpoint_two(eps[79:64]),
		.blue_endpoint_two(eps[63:48]), .red_endpoint_three(eps[47:32]),
		.green_endpoint_three(eps[31:16]), .blue_endpoint_three(eps[15:0])
	);

	// Low bits, error, mode, transformed, partition, base, deltas
	function automatic logic [36:0] pk(input int lo, m, t, p, e, r, g, b);
		return {5'(lo), 1'b0, 5'(m), 1'(t), 5'(p), 5'(e), 5'(r), 5'(g), 5'(b)};
	endfunction

	function automatic logic [36:0] er(input int lo);
		return {5'(lo), 1'b1, 5'(lo), 26'h0};
	endfunction

	function automatic logic [5:0] rv6(input logic [5:0] x);
		for (int i = 0; i < 6; i++) rv6[i] = x[5 - i];
	endfunction

	localparam logic [36:0] TAB [18] = '{
		pk(28, 0, 1, 5, 10, 5, 5, 5),
		pk(29, 1, 1, 5, 7, 6, 6, 6),
		pk(2, 2, 1, 5, 11, 5, 4, 4),
		pk(6, 6, 1, 5, 11, 4, 5, 4),
		pk(10, 10, 1, 5, 11, 4, 4, 5),
		pk(14, 14, 1, 5, 9, 5, 5, 5),
		pk(18, 18, 1, 5, 8, 6, 5, 5),
		pk(22, 22, 1, 5, 8, 5, 6, 5),
		pk(26, 26, 1, 5, 8, 5, 5, 6),
		pk(30, 30, 0, 5, 6, 6, 6, 6),
		pk(3, 3, 0, 0, 10, 10, 10, 10),
		pk(7, 7, 1, 0, 11, 9, 9, 9),
		pk(11, 11, 1, 0, 12, 8, 8, 8),
		pk(15, 15, 1, 0, 16, 4, 4, 4),
		er(19),
		er(23),
		er(27),
		er(31)
	};

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic cmp(input logic [191:0] got, input logic [191:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic report_and_stop();
		if (fail_count == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic step();
		@(posedge clk);
		#1;
	endtask

	task automatic run(input logic [127:0] b);
		int n;
		go = 1'b1;
		blk = b;
		step();
		go = 1'b0;
		n = 1;
		while (vld !== 1'b1 && n < 8) begin
			step();
			n++;
		end
		cmp(192'(n), 192'(`HTU_LATENCY));
		if (vld !== 1'b1) begin
			fail_count++;
			report_and_stop();
		end
	endtask

	// One 65-bit format: endpoints, index data, one-cycle valid
	task automatic t_ep(input logic [127:0] b, input logic [15:0] r0, g0, b0, r1, g1, b1, m);
		run(b);
		if (m != 16'h0000) begin
			r1 = (r0 + r1) & m;
			g1 = (g0 + g1) & m;
			b1 = (b0 + b1) & m;
		end
		cmp(eps, {r0, g0, b0, r1, g1, b1, {2{r0 & m, g0 & m, b0 & m}}});
		cmp(192'({part, idx}), 192'({5'h00, b >> 65}));
		step();
		cmp(192'(vld), 192'h0);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_modes();
		logic [36:0] e;
		for (int k = 0; k < 19; k++) begin
			go = (k < 18);
			blk = {123'h0, TAB[k % 18][36:32]};
			step();
			if (k > 0) begin
				e = TAB[k - 1];
				cmp(192'({vld, info}), 192'({1'b1, e[31:0]}));
				if (e[31]) begin
					cmp(eps, 192'h0);
					cmp(192'({part, idx}), 192'h0);
				end
			end
		end
		step();
		cmp(192'(vld), 192'h0);
	endtask

	task automatic t_m15();
		logic [15:0] r0 = 16'hFFF3, g0 = 16'h8001, b0 = 16'h3C5A;
		t_ep({63'h5A5A_1234_5678_9ABC, rv6(b0[15:10]), 4'h6, rv6(g0[15:10]), 4'h9, rv6(r0[15:10]), 4'hF,
			b0[9:0], g0[9:0], r0[9:0], 5'h0F}, r0, g0, b0, 16'h000F, 16'h0009, 16'h0006, 16'hFFFF);
	endtask

	task automatic t_m7();
		logic [15:0] r0 = 16'h07F0, g0 = 16'h0400, b0 = 16'h02B5, r1 = 16'h01FF, g1 = 16'h00AA, b1 = 16'h0155;
		t_ep({63'h7E5A_0F0F_C3C3_3C3C, b0[10], b1[8:0], g0[10], g1[8:0], r0[10], r1[8:0],
			b0[9:0], g0[9:0], r0[9:0], 5'h07}, r0, g0, b0, r1, g1, b1, 16'h07FF);
	endtask

	task automatic t_m11();
		logic [15:0] r0 = 16'h0A5C, g0 = 16'h0421, b0 = 16'h0C3F, r1 = 16'h0081, g1 = 16'h00FE, b1 = 16'h0033;
		t_ep({63'h1B3D_6E0F_A5C3_7788, b0[10], b0[11], b1[7:0], g0[10], g0[11], g1[7:0], r0[10], r0[11], r1[7:0],
			b0[9:0], g0[9:0], r0[9:0], 5'h0B}, r0, g0, b0, r1, g1, b1, 16'h0FFF);
	endtask

	// Every field bit set: each endpoint fills to six bits, partition follows
	task automatic t_m30();
		logic [127:0] b = {46'h2A5F_0C3E_91B7, 5'h13, {72{1'b1}}, 5'h1E};
		run(b);
		cmp(eps, {12{16'h003F}});
		cmp(192'({part, idx}), 192'({5'h13, b >> 82}));
		step();
		cmp(192'(vld), 192'h0);
	endtask

	task automatic t_m3();
		logic [15:0] r0 = 16'h0321, g0 = 16'h0154, b0 = 16'h03FF, r1 = 16'h0000, g1 = 16'h02AA, b1 = 16'h0187;
		t_ep({63'h2AAA_5555_0F0F_F0F0, b1[9:0], g1[9:0], r1[9:0], b0[9:0], g0[9:0], r0[9:0], 5'h03},
			r0, g0, b0, r1, g1, b1, 16'h0000);
	endtask

	initial begin
		repeat (16) @(posedge clk);
		#1;
		rst = 1'b0;
		t_modes();
		t_m15();
		t_m7();
		t_m3();
		t_m11();
		t_m30();
		report_and_stop();
	end
endmodule

`default_nettype wire
